// [hw/aicrf_pkg.sv]
// Constants, types and helpers for the converter control and result buffer
package aicrf_pkg;

  localparam int CLK_PERIOD_NS = 25;
  localparam int OSC_FREQ_KHZ = 4400;
  localparam int OSC_TOL_PCT = 10;
  localparam int ACQ_MIN_NS = 1400;
  localparam int ACQ_MIN_CYC = (ACQ_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONV_OSC_TICKS = 11;
  localparam int CONV_TIME_NS = CONV_OSC_TICKS * 1000000 / OSC_FREQ_KHZ;
  localparam int CONV_CYC = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TEMP_TIME_NS = 20000;
  localparam int TEMP_CYC = (TEMP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REF_WAKE_NS = 65000;
  localparam int REF_WAKE_CYC = (REF_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMER_W = 12;

  localparam int FIFO_DEPTH = 16;
  localparam int NUM_CH = 16;
  localparam int NUM_PAIRS = NUM_CH / 2;
  localparam int WINDOW_BITS = 32;
  localparam int LEAD_ZEROS = 4;

  localparam logic [1:0] CKMODE_PIN_SCAN = 2'b00;
  localparam logic [1:0] CKMODE_PIN_EACH = 2'b01;
  localparam logic [1:0] CKMODE_SERIAL = 2'b10;
  localparam logic [1:0] CKMODE_EXTERNAL = 2'b11;
  localparam logic [1:0] PAIRSEL_UNIPOLAR = 2'b10;
  localparam logic [1:0] PAIRSEL_BIPOLAR = 2'b11;

  localparam logic signed [10:0] UNI_MAX = 11'sh3ff;
  localparam logic signed [10:0] BIP_MAX = 11'sh1ff;
  localparam logic signed [10:0] BIP_MIN = -11'sh200;

  typedef struct packed {
    logic [9:0] code;
    logic [1:0] sub;
  } aicrf_result_t;

  typedef struct packed {
    logic pos_is_gnd_unused;
    logic [3:0] pos_ch;
    logic [3:0] neg_ch;
    logic neg_gnd;
  } aicrf_mux_t;

  typedef enum logic [2:0] {ST_IDLE, ST_WAKE, ST_TEMP, ST_ACQ, ST_CONV} aicrf_state_t;

  function automatic logic [3:0] aicrf_gray2bin(input logic [3:0] g);
    logic [3:0] b;
    b[3] = g[3];
    for (int i = 2; i >= 0; i--) begin
      b[i] = b[i + 1] ^ g[i];
    end
    return b;
  endfunction : aicrf_gray2bin

  function automatic logic [3:0] aicrf_bin2gray(input logic [3:0] b);
    return b ^ (b >> 1);
  endfunction : aicrf_bin2gray

endpackage : aicrf_pkg

// [hw/aicrf_top.sv]
// Converter sequencing, input pairing, result buffer and serial readout
`timescale 1ns/1ps
`default_nettype none
module aicrf_top
  import aicrf_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH,
  parameter logic [3:0] START_PIN_CH = 4'hf,
  parameter logic [3:0] REF_NEG_CH = 4'he
) (
  input wire logic CLOCK_IN,
  input wire logic RST_B_IN,
  input wire logic SCLK_IN,
  input wire logic CS_B_IN,
  output logic SDO_OUT,
  output logic SDO_OE_OUT,
  input wire logic CONV_START_PIN_B_IN,
  input wire logic [1:0] CLOCK_MODE_SELECT_IN,
  input wire logic START_PIN_ROLE_IN,
  input wire logic REF_NEG_ROLE_IN,
  input wire logic [1:0] PAIR_REGISTER_SELECT_IN,
  input wire logic [7:0] PAIR_BYTE_IN,
  input wire logic PAIR_WRITE_IN,
  input wire logic CONV_WRITE_IN,
  input wire logic [3:0] CHANNEL_IN,
  input wire logic [4:0] RESULT_COUNT_IN,
  input wire logic TEMP_REQ_IN,
  input wire logic REF_WAKE_NEEDED_IN,
  input wire logic signed [10:0] DIFF_CODE_IN,
  input wire logic [1:0] SUB_BITS_IN,
  input wire logic [11:0] TEMP_CODE_IN,
  output logic [3:0] POS_SEL_OUT,
  output logic [3:0] NEG_SEL_OUT,
  output logic NEG_TO_GND_OUT,
  output logic TRACK_OUT,
  output logic BUSY_OUT,
  output logic EOC_B_OUT,
  output logic OSC_ENABLE_OUT,
  output logic [4:0] FIFO_COUNT_OUT,
  output logic [NUM_PAIRS-1:0] UNIPOLAR_PAIRS_OUT,
  output logic [NUM_PAIRS-1:0] BIPOLAR_PAIRS_OUT
);

  // Pair index p sits at byte bit (NUM_PAIRS-1-p)
  function automatic logic [NUM_PAIRS-1:0] byte_to_pairs(input logic [7:0] b);
    logic [NUM_PAIRS-1:0] p;
    for (int i = 0; i < NUM_PAIRS; i++) begin
      p[i] = b[NUM_PAIRS - 1 - i];
    end
    return p;
  endfunction : byte_to_pairs

  function automatic logic [15:0] fmt_result(input aicrf_result_t r);
    return {{LEAD_ZEROS{1'b0}}, r.code, r.sub};
  endfunction : fmt_result

  logic [NUM_PAIRS-1:0] uni_ff;
  logic [NUM_PAIRS-1:0] bip_ff;
  logic cs_meta_ff, cs_sync_ff, cs_prev_ff;
  logic pin_meta_ff, pin_sync_ff, pin_prev_ff;
  logic link_clr_ff;
  logic [3:0] byte_gray_ff;
  logic [3:0] gray_meta_ff, gray_sync_ff;
  logic [3:0] seen_ff;
  logic [5:0] bit_cnt_ff;
  logic [WINDOW_BITS-1:0] window_ff;
  logic [WINDOW_BITS-1:0] nxt_window;
  aicrf_state_t state_ff;
  logic [TIMER_W-1:0] timer_ff;
  logic [3:0] ch_ff;
  logic [4:0] left_ff;
  logic temp_pend_ff;
  logic single_ff;
  aicrf_result_t mem_ff [DEPTH];
  logic [3:0] head_ff, tail_ff;
  logic [4:0] count_ff;
  logic half_ff;
  logic [11:0] temp_ff;
  logic temp_valid_ff;

  // Channel decode for the channel now being sequenced
  logic [2:0] pair_idx;
  logic is_diff, is_bip, ch_blocked;
  logic [3:0] pos_ch, neg_ch, step_ch;
  always_comb begin
    pair_idx = ch_ff[3:1];
    is_diff = uni_ff[pair_idx] | bip_ff[pair_idx];
    is_bip = bip_ff[pair_idx] & ~uni_ff[pair_idx];
    pos_ch = is_diff ? {pair_idx, 1'b0} : ch_ff;
    neg_ch = {pair_idx, 1'b1};
    ch_blocked = (START_PIN_ROLE_IN & (pos_ch == START_PIN_CH ||
                  (is_diff && neg_ch == START_PIN_CH))) |
                 (REF_NEG_ROLE_IN & (pos_ch == REF_NEG_CH ||
                  (is_diff && neg_ch == REF_NEG_CH)));
    step_ch = is_diff ? pos_ch + 4'h2 : ch_ff + 4'h1;
  end

  // Result coding from the signed difference at hold
  logic [9:0] res_code;
  always_comb begin
    if (is_bip) begin
      if (DIFF_CODE_IN > BIP_MAX) begin
        res_code = BIP_MAX[9:0];
      end else if (DIFF_CODE_IN < BIP_MIN) begin
        res_code = BIP_MIN[9:0];
      end else begin
        res_code = DIFF_CODE_IN[9:0];
      end
    end else begin
      if (DIFF_CODE_IN[10]) begin
        res_code = 10'h000;
      end else begin
        res_code = DIFF_CODE_IN[9:0];
      end
    end
  end

  always_ff @(posedge CLOCK_IN) begin
    if (!RST_B_IN) begin
      uni_ff <= '0;
      bip_ff <= '0;
    end else if (PAIR_WRITE_IN) begin
      if (PAIR_REGISTER_SELECT_IN == PAIRSEL_UNIPOLAR) begin
        uni_ff <= byte_to_pairs(PAIR_BYTE_IN);
      end else if (PAIR_REGISTER_SELECT_IN == PAIRSEL_BIPOLAR) begin
        bip_ff <= byte_to_pairs(PAIR_BYTE_IN);
      end
    end
  end

  // Pin synchronisers; only the second and third stages feed logic
  always_ff @(posedge CLOCK_IN) begin
    if (!RST_B_IN) begin
      cs_meta_ff <= 1'b1;
      cs_sync_ff <= 1'b1;
      cs_prev_ff <= 1'b1;
      pin_meta_ff <= 1'b1;
      pin_sync_ff <= 1'b1;
      pin_prev_ff <= 1'b1;
    end else begin
      cs_meta_ff <= CS_B_IN;
      cs_sync_ff <= cs_meta_ff;
      cs_prev_ff <= cs_sync_ff;
      pin_meta_ff <= CONV_START_PIN_B_IN;
      pin_sync_ff <= pin_meta_ff;
      pin_prev_ff <= pin_sync_ff;
    end
  end

  always_ff @(posedge CLOCK_IN) begin
    link_clr_ff <= ~RST_B_IN;
  end

  logic pin_fall, cs_rise, cs_fall;
  logic start_scan, start_single;
  assign pin_fall = START_PIN_ROLE_IN & pin_prev_ff & ~pin_sync_ff;
  assign cs_rise = ~cs_prev_ff & cs_sync_ff;
  assign cs_fall = cs_prev_ff & ~cs_sync_ff;
  assign start_scan = (state_ff == ST_IDLE) &
                      ((CLOCK_MODE_SELECT_IN == CKMODE_SERIAL & CONV_WRITE_IN) |
                       (CLOCK_MODE_SELECT_IN == CKMODE_PIN_SCAN & pin_fall));
  assign start_single = (state_ff == ST_IDLE) &
                        ((CLOCK_MODE_SELECT_IN == CKMODE_PIN_EACH & pin_fall) |
                         (CLOCK_MODE_SELECT_IN == CKMODE_EXTERNAL & cs_rise));

  logic res_push, temp_push, acq_done, last_result;
  assign acq_done = (timer_ff == '0) &
                    ((CLOCK_MODE_SELECT_IN != CKMODE_PIN_EACH) | pin_sync_ff);
  assign last_result = (left_ff <= 5'd1);
  assign res_push = (state_ff == ST_CONV) & (timer_ff == '0);
  assign temp_push = (state_ff == ST_TEMP) & (timer_ff == '0);

  // Sequencer: wake, temperature, then acquire and convert per result
  always_ff @(posedge CLOCK_IN) begin
    if (!RST_B_IN) begin
      state_ff <= ST_IDLE;
      timer_ff <= '0;
      ch_ff <= '0;
      left_ff <= '0;
      temp_pend_ff <= 1'b0;
      single_ff <= 1'b0;
    end else begin
      unique case (state_ff)
        ST_IDLE: begin
          if (start_scan | start_single) begin
            ch_ff <= CHANNEL_IN;
            single_ff <= start_single;
            if (start_single || RESULT_COUNT_IN == 5'd0) begin
              left_ff <= 5'd1;
            end else begin
              left_ff <= RESULT_COUNT_IN;
            end
            temp_pend_ff <= TEMP_REQ_IN;
            state_ff <= ST_WAKE;
            timer_ff <= REF_WAKE_NEEDED_IN ? TIMER_W'(REF_WAKE_CYC) : '0;
          end
        end
        ST_WAKE: begin
          if (timer_ff != '0) begin
            timer_ff <= timer_ff - 1'b1;
          end else if (temp_pend_ff) begin
            state_ff <= ST_TEMP;
            timer_ff <= TIMER_W'(TEMP_CYC - 1);
          end else begin
            state_ff <= ST_ACQ;
            timer_ff <= TIMER_W'(ACQ_MIN_CYC - 1);
          end
        end
        ST_TEMP: begin
          if (timer_ff != '0) begin
            timer_ff <= timer_ff - 1'b1;
          end else begin
            temp_pend_ff <= 1'b0;
            state_ff <= ST_ACQ;
            timer_ff <= TIMER_W'(ACQ_MIN_CYC - 1);
          end
        end
        ST_ACQ: begin
          if (ch_blocked) begin
            ch_ff <= step_ch;
            left_ff <= left_ff - 1'b1;
            timer_ff <= TIMER_W'(ACQ_MIN_CYC - 1);
            if (last_result) begin
              state_ff <= ST_IDLE;
            end
          end else if (timer_ff != '0) begin
            timer_ff <= timer_ff - 1'b1;
          end else if (acq_done) begin
            state_ff <= ST_CONV;
            timer_ff <= TIMER_W'(CONV_CYC - 1);
          end
        end
        ST_CONV: begin
          if (timer_ff != '0) begin
            timer_ff <= timer_ff - 1'b1;
          end else begin
            ch_ff <= step_ch;
            left_ff <= left_ff - 1'b1;
            timer_ff <= TIMER_W'(ACQ_MIN_CYC - 1);
            state_ff <= last_result ? ST_IDLE : ST_ACQ;
          end
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // Track/hold switch settings and status outputs
  always_ff @(posedge CLOCK_IN) begin
    if (!RST_B_IN) begin
      POS_SEL_OUT <= '0;
      NEG_SEL_OUT <= '0;
      NEG_TO_GND_OUT <= 1'b1;
      TRACK_OUT <= 1'b0;
      BUSY_OUT <= 1'b0;
      OSC_ENABLE_OUT <= 1'b0;
    end else begin
      POS_SEL_OUT <= pos_ch;
      NEG_SEL_OUT <= is_diff ? neg_ch : '0;
      NEG_TO_GND_OUT <= ~is_diff;
      TRACK_OUT <= (state_ff == ST_ACQ) & ~ch_blocked;
      BUSY_OUT <= (state_ff != ST_IDLE);
      OSC_ENABLE_OUT <= (CLOCK_MODE_SELECT_IN != CKMODE_EXTERNAL);
    end
  end

  always_ff @(posedge CLOCK_IN) begin
    if (!RST_B_IN) begin
      EOC_B_OUT <= 1'b1;
    end else if (CLOCK_MODE_SELECT_IN == CKMODE_EXTERNAL || cs_fall || pin_fall) begin
      EOC_B_OUT <= 1'b1;
    end else if ((res_push | (state_ff == ST_ACQ & ch_blocked)) & last_result) begin
      EOC_B_OUT <= 1'b0;
    end
  end

  // Byte consumption arrives from the serial side as a gray count
  logic [3:0] link_bytes;
  logic consume, front_temp, pop, temp_clear, full;
  assign link_bytes = aicrf_gray2bin(gray_sync_ff);
  assign consume = cs_sync_ff & (seen_ff != link_bytes);
  assign front_temp = temp_valid_ff;
  assign pop = consume & half_ff & ~front_temp & (count_ff != '0);
  assign temp_clear = consume & half_ff & front_temp;
  assign full = (count_ff == 5'(DEPTH));

  always_ff @(posedge CLOCK_IN) begin
    if (!RST_B_IN) begin
      gray_meta_ff <= '0;
      gray_sync_ff <= '0;
      seen_ff <= '0;
    end else begin
      gray_meta_ff <= byte_gray_ff;
      gray_sync_ff <= gray_meta_ff;
      if (consume) begin
        seen_ff <= seen_ff + 4'h1;
      end
    end
  end

  always_ff @(posedge CLOCK_IN) begin
    if (res_push) begin
      mem_ff[tail_ff] <= '{code: res_code, sub: SUB_BITS_IN};
    end
  end

  always_ff @(posedge CLOCK_IN) begin
    if (!RST_B_IN) begin
      head_ff <= '0;
      tail_ff <= '0;
      count_ff <= '0;
    end else begin
      if (res_push) begin
        tail_ff <= tail_ff + 4'h1;
      end
      if (pop || (res_push && full)) begin
        head_ff <= head_ff + 4'h1;
      end
      if (res_push && !full && !pop) begin
        count_ff <= count_ff + 5'd1;
      end else if (pop && !res_push) begin
        count_ff <= count_ff - 5'd1;
      end
    end
  end

  always_ff @(posedge CLOCK_IN) begin
    if (!RST_B_IN) begin
      temp_ff <= '0;
      temp_valid_ff <= 1'b0;
    end else if (temp_push) begin
      temp_ff <= TEMP_CODE_IN;
      temp_valid_ff <= 1'b1;
    end else if (temp_clear) begin
      temp_valid_ff <= 1'b0;
    end
  end

  // Byte position within the front item
  always_ff @(posedge CLOCK_IN) begin
    if (!RST_B_IN) begin
      half_ff <= 1'b0;
    end else if (front_temp && temp_push) begin
      half_ff <= 1'b0;
    end else if (!front_temp && res_push && full && !pop) begin
      half_ff <= 1'b0;
    end else if (consume && (front_temp || count_ff != '0)) begin
      half_ff <= ~half_ff;
    end
  end

  // Four-byte read window, frozen while chip select is low
  logic [47:0] stream;
  logic [15:0] word_q [3];
  always_comb begin
    logic [4:0] idx;
    idx = '0;
    for (int k = 0; k < 3; k++) begin
      if (front_temp && k == 0) begin
        word_q[k] = {{LEAD_ZEROS{1'b0}}, temp_ff};
      end else begin
        idx = 5'(k) - {4'h0, front_temp};
        if (idx < count_ff) begin
          word_q[k] = fmt_result(mem_ff[head_ff + idx[3:0]]);
        end else begin
          word_q[k] = '0;
        end
      end
    end
    stream = {word_q[0], word_q[1], word_q[2]};
    nxt_window = half_ff ? stream[39:8] : stream[47:16];
  end

  always_ff @(posedge CLOCK_IN) begin
    if (!RST_B_IN) begin
      window_ff <= '0;
    end else if (cs_sync_ff) begin
      window_ff <= nxt_window;
    end
  end

  always_ff @(posedge CLOCK_IN) begin
    if (!RST_B_IN) begin
      FIFO_COUNT_OUT <= '0;
      UNIPOLAR_PAIRS_OUT <= '0;
      BIPOLAR_PAIRS_OUT <= '0;
    end else begin
      FIFO_COUNT_OUT <= count_ff;
      UNIPOLAR_PAIRS_OUT <= uni_ff;
      BIPOLAR_PAIRS_OUT <= bip_ff;
    end
  end

  // Serial clock domain: bits sampled on rising edge, bit count cleared by frame end, byte count only by reset
  always_ff @(posedge SCLK_IN or posedge CS_B_IN) begin
    if (CS_B_IN) begin
      bit_cnt_ff <= '0;
    end else if (bit_cnt_ff != 6'(WINDOW_BITS)) begin
      bit_cnt_ff <= bit_cnt_ff + 6'd1;
    end
  end

  always_ff @(posedge SCLK_IN or posedge link_clr_ff) begin
    if (link_clr_ff) begin
      byte_gray_ff <= '0;
    end else if (!CS_B_IN && bit_cnt_ff != 6'(WINDOW_BITS) && bit_cnt_ff[2:0] == 3'h7) begin
      byte_gray_ff <= aicrf_bin2gray(aicrf_gray2bin(byte_gray_ff) + 4'h1);
    end
  end

  // Data changes on the falling edge, MSB of the oldest byte first
  always_ff @(negedge SCLK_IN or posedge CS_B_IN) begin
    if (CS_B_IN) begin
      SDO_OUT <= 1'b0;
      SDO_OE_OUT <= 1'b0;
    end else begin
      SDO_OE_OUT <= 1'b1;
      if (bit_cnt_ff < 6'(WINDOW_BITS)) begin
        SDO_OUT <= window_ff[5'(WINDOW_BITS - 1) - bit_cnt_ff[4:0]];
      end else begin
        SDO_OUT <= 1'b0;
      end
    end
  end

endmodule : aicrf_top
`default_nettype wire

// [testbench/aicrf_sva.sv]
// Concurrent checks on the converter control and readout ports
`timescale 1ns/1ps
`default_nettype none
module aicrf_sva
  import aicrf_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH,
  parameter logic [3:0] START_PIN_CH = 4'hf,
  parameter logic [3:0] REF_NEG_CH = 4'he
) (
  input wire logic CLOCK_IN,
  input wire logic RST_B_IN,
  input wire logic CS_B_IN,
  input wire logic SDO_OUT,
  input wire logic SDO_OE_OUT,
  input wire logic [1:0] CLOCK_MODE_SELECT_IN,
  input wire logic START_PIN_ROLE_IN,
  input wire logic REF_NEG_ROLE_IN,
  input wire logic CONV_WRITE_IN,
  input wire logic [3:0] POS_SEL_OUT,
  input wire logic [3:0] NEG_SEL_OUT,
  input wire logic NEG_TO_GND_OUT,
  input wire logic TRACK_OUT,
  input wire logic BUSY_OUT,
  input wire logic EOC_B_OUT,
  input wire logic OSC_ENABLE_OUT,
  input wire logic [4:0] FIFO_COUNT_OUT,
  input wire logic [NUM_PAIRS-1:0] UNIPOLAR_PAIRS_OUT,
  input wire logic [NUM_PAIRS-1:0] BIPOLAR_PAIRS_OUT
);
  default clocking cb @(posedge CLOCK_IN);
  endclocking
  default disable iff (!RST_B_IN);

  // Length of the current tracking phase, saturating
  logic [7:0] trk_cnt_ff;
  logic [7:0] nxt_trk_cnt;
  always_comb begin
    nxt_trk_cnt = TRACK_OUT ? trk_cnt_ff + ((trk_cnt_ff == 8'hff) ? 8'h00 : 8'h01) : 8'h00;
  end
  always_ff @(posedge CLOCK_IN) begin
    if (!RST_B_IN) begin
      trk_cnt_ff <= 8'h00;
    end else begin
      trk_cnt_ff <= nxt_trk_cnt;
    end
  end

  property p_osc_mode;
    $past(RST_B_IN) |-> OSC_ENABLE_OUT == ($past(CLOCK_MODE_SELECT_IN) != 2'b11);
  endproperty
  a_osc_mode: assert property (p_osc_mode) else $error("oscillator enable wrong for mode");
  property p_start_serial;
    CONV_WRITE_IN && !BUSY_OUT && CLOCK_MODE_SELECT_IN == 2'b10 |-> ##[1:2] BUSY_OUT;
  endproperty
  a_start_serial: assert property (p_start_serial) else $error("write did not start scan");
  property p_acq_min;
    $fell(TRACK_OUT) |-> trk_cnt_ff >= ACQ_MIN_CYC;
  endproperty
  a_acq_min: assert property (p_acq_min) else $error("acquisition too short");
  property p_pair_route;
    TRACK_OUT && !NEG_TO_GND_OUT |-> !POS_SEL_OUT[0] && NEG_SEL_OUT == (POS_SEL_OUT | 4'h1);
  endproperty
  a_pair_route: assert property (p_pair_route) else $error("pair routing wrong");
  property p_gnd_route;
    TRACK_OUT |-> NEG_TO_GND_OUT == !(UNIPOLAR_PAIRS_OUT[POS_SEL_OUT[3:1]]
      || BIPOLAR_PAIRS_OUT[POS_SEL_OUT[3:1]]);
  endproperty
  a_gnd_route: assert property (p_gnd_route) else $error("negative side routing wrong");
  property p_shared_pin;
    TRACK_OUT |-> !(START_PIN_ROLE_IN && POS_SEL_OUT == START_PIN_CH)
      && !(REF_NEG_ROLE_IN && POS_SEL_OUT == REF_NEG_CH);
  endproperty
  a_shared_pin: assert property (p_shared_pin) else $error("shared pin sampled");
  property p_fifo_cap;
    FIFO_COUNT_OUT <= DEPTH;
  endproperty
  a_fifo_cap: assert property (p_fifo_cap) else $error("buffer count above depth");
  property p_fifo_step;
    FIFO_COUNT_OUT > $past(FIFO_COUNT_OUT) |-> FIFO_COUNT_OUT == $past(FIFO_COUNT_OUT) + 5'h01;
  endproperty
  a_fifo_step: assert property (p_fifo_step) else $error("buffer count jumped");
  property p_eoc_idle;
    $fell(EOC_B_OUT) |-> ##[0:1] !BUSY_OUT;
  endproperty
  a_eoc_idle: assert property (p_eoc_idle) else $error("end of conversion while busy");
  property p_sdo_idle;
    CS_B_IN && $past(CS_B_IN) |-> !SDO_OUT && !SDO_OE_OUT;
  endproperty
  a_sdo_idle: assert property (p_sdo_idle) else $error("serial output active while idle");
  c_diff_track: cover property (TRACK_OUT && !NEG_TO_GND_OUT);
  c_fifo_full: cover property (FIFO_COUNT_OUT == DEPTH);
  c_eoc: cover property ($fell(EOC_B_OUT));
endmodule : aicrf_sva

bind aicrf_top aicrf_sva #(.DEPTH(DEPTH), .START_PIN_CH(START_PIN_CH), .REF_NEG_CH(REF_NEG_CH))
  u_sva (.CLOCK_IN(CLOCK_IN), .RST_B_IN(RST_B_IN), .CS_B_IN(CS_B_IN), .SDO_OUT(SDO_OUT),
  .SDO_OE_OUT(SDO_OE_OUT), .CLOCK_MODE_SELECT_IN(CLOCK_MODE_SELECT_IN),
  .START_PIN_ROLE_IN(START_PIN_ROLE_IN), .REF_NEG_ROLE_IN(REF_NEG_ROLE_IN),
  .CONV_WRITE_IN(CONV_WRITE_IN), .POS_SEL_OUT(POS_SEL_OUT), .NEG_SEL_OUT(NEG_SEL_OUT),
  .NEG_TO_GND_OUT(NEG_TO_GND_OUT), .TRACK_OUT(TRACK_OUT), .BUSY_OUT(BUSY_OUT),
  .EOC_B_OUT(EOC_B_OUT), .OSC_ENABLE_OUT(OSC_ENABLE_OUT), .FIFO_COUNT_OUT(FIFO_COUNT_OUT),
  .UNIPOLAR_PAIRS_OUT(UNIPOLAR_PAIRS_OUT), .BIPOLAR_PAIRS_OUT(BIPOLAR_PAIRS_OUT));
`default_nettype wire

// [testbench/aicrf_host.sv]
// Serial master model that reads result bytes from the converter
`timescale 1ns/1ps
`default_nettype none
module aicrf_host (
  output logic sclk_out,
  output logic cs_b_out,
  input wire logic sdo_in,
  input wire logic sdo_oe_in
);
  logic last_ff = 1'b0;
  logic line;
  // A released line shows the inverse of its last level
  assign line = sdo_oe_in ? sdo_in : ~last_ff;
  initial begin
    sclk_out = 1'b1;
    cs_b_out = 1'b1;
  end
  // Clock idles high and stands still outside frames
  task automatic frame(input int n, output logic [31:0] d);
    d = 32'h0000_0000;
    cs_b_out = 1'b0;
    #150;
    for (int i = 0; i < n * 8; i++) begin
      sclk_out = 1'b0;
      #24;
      d = {d[30:0], line};
      last_ff = line;
      sclk_out = 1'b1;
      #24;
    end
    cs_b_out = 1'b1;
    #300;
  endtask : frame
endmodule : aicrf_host
`default_nettype wire

// [testbench/aicrf_bench.sv]
// Self-checking bench for the converter control and result buffer
`timescale 1ns/1ps
`default_nettype none
module aicrf_bench
  import aicrf_pkg::*;
();
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic pin_b = 1'b1;
  logic spr = 1'b0, sng = 1'b0, pwr = 1'b0, cwr = 1'b0, tq = 1'b0, wk = 1'b0;
  logic [1:0] mode = 2'b10, psel = 2'b00, sub = 2'b10;
  logic [7:0] pbyte = 8'h00;
  logic [3:0] ch = 4'h0;
  logic [4:0] cnt = 5'h01;
  logic signed [10:0] diff = 11'sh000;
  logic [11:0] temp = 12'h000;
  logic sclk, cs_b, sdo, sdo_oe, ngnd, trk, busy, eoc_b, osc;
  logic [3:0] pos, neg;
  logic [4:0] fcnt;
  logic [7:0] uni, bip;
  int error_cnt = 0;
  int check_count = 0;
  int cycles = 0;
  logic [3:0] tch [6] = '{4'h0, 4'h0, 4'h2, 4'h4, 4'h6, 4'h7};
  logic signed [10:0] tdf [6] = '{-11'sh005, 11'sh12c, -11'sh005, -11'sh005, -11'sh005, 11'sh2bc};
  logic [9:0] tcd [6] = '{10'h000, 10'h12c, 10'h3fb, 10'h000, 10'h000, 10'h2bc};

  aicrf_top u_dut (.CLOCK_IN(clk), .RST_B_IN(rst_b), .SCLK_IN(sclk), .CS_B_IN(cs_b),
    .SDO_OUT(sdo), .SDO_OE_OUT(sdo_oe), .CONV_START_PIN_B_IN(pin_b),
    .CLOCK_MODE_SELECT_IN(mode), .START_PIN_ROLE_IN(spr), .REF_NEG_ROLE_IN(sng),
    .PAIR_REGISTER_SELECT_IN(psel), .PAIR_BYTE_IN(pbyte), .PAIR_WRITE_IN(pwr),
    .CONV_WRITE_IN(cwr), .CHANNEL_IN(ch), .RESULT_COUNT_IN(cnt), .TEMP_REQ_IN(tq),
    .REF_WAKE_NEEDED_IN(wk), .DIFF_CODE_IN(diff), .SUB_BITS_IN(sub), .TEMP_CODE_IN(temp),
    .POS_SEL_OUT(pos), .NEG_SEL_OUT(neg), .NEG_TO_GND_OUT(ngnd), .TRACK_OUT(trk),
    .BUSY_OUT(busy), .EOC_B_OUT(eoc_b), .OSC_ENABLE_OUT(osc), .FIFO_COUNT_OUT(fcnt),
    .UNIPOLAR_PAIRS_OUT(uni), .BIPOLAR_PAIRS_OUT(bip));
  aicrf_host u_host (.sclk_out(sclk), .cs_b_out(cs_b), .sdo_in(sdo), .sdo_oe_in(sdo_oe));

  always #12.5 clk = ~clk;

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_of_test

  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      error_cnt++;
      end_of_test();
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : cyc

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  function automatic logic [15:0] wd(input logic [9:0] c);
    return {4'h0, c, 2'b10};
  endfunction : wd

  task automatic wait_idle(output int t);
    int w;
    w = 0;
    while (busy !== 1'b1 && w < 20) begin
      cyc(1);
      w++;
    end
    t = 0;
    while (busy === 1'b1 && t < 9000) begin
      cyc(1);
      t++;
    end
  endtask : wait_idle

  task automatic pw(input logic [1:0] s, input logic [7:0] b);
    psel = s;
    pbyte = b;
    pwr = 1'b1;
    cyc(1);
    pwr = 1'b0;
    cyc(1);
  endtask : pw

  // Starts a scan by a conversion write and optionally checks its length
  task automatic conv(input logic [3:0] c, input logic [4:0] n, input logic q, input logic w,
      input logic signed [10:0] d, input logic tm);
    int t;
    int e;
    ch = c;
    cnt = n;
    tq = q;
    wk = w;
    diff = d;
    cwr = 1'b1;
    cyc(1);
    cwr = 1'b0;
    wait_idle(t);
    e = n * (ACQ_MIN_CYC + CONV_CYC) + (q ? TEMP_CYC : 0) + (w ? REF_WAKE_CYC : 0);
    check(32'(!tm || (t >= e && t <= e + 4 * n + 8)), 32'h0000_0001);
  endtask : conv

  task automatic rd(input int n, input logic [31:0] exp);
    logic [31:0] d;
    u_host.frame(n, d);
    cyc(1);
    check(d, exp);
  endtask : rd

  initial begin
    logic [31:0] d;
    int t;
    cyc(3);
    rst_b = 1'b1;
    cyc(2);
    check(32'({fcnt, eoc_b, ngnd, busy, uni, bip}), 32'h0006_0000);
    rd(2, 32'h0000_0000);
    pw(2'b10, 8'ha0);
    pw(2'b11, 8'h60);
    pw(2'b01, 8'hff);
    pw(2'b00, 8'hff);
    // Pair outputs are indexed by pair number, pair 0 in bit 0
    check(32'({uni, bip}), 32'h0000_0506);
    for (int i = 0; i < 6; i++) begin
      conv(tch[i], 5'h01, 1'b0, 1'b0, tdf[i], 1'b1);
      rd(2, 32'(wd(tcd[i])));
    end
    conv(4'h6, 5'h03, 1'b0, 1'b0, 11'sh2bc, 1'b1);
    for (int i = 1; i <= 18; i++) begin
      conv(4'h8, 5'h01, 1'b0, 1'b0, 11'(i), 1'b1);
    end
    check(32'(fcnt), 32'(FIFO_DEPTH));
    for (int i = 3; i <= 17; i += 2) begin
      rd(4, {wd(10'(i)), wd(10'(i + 1))});
    end
    rd(2, 32'h0000_0000);
    conv(4'h8, 5'h01, 1'b0, 1'b0, 11'sh155, 1'b0);
    rd(1, 32'h0000_0005);
    check(32'(fcnt), 32'h0000_0001);
    rd(2, 32'h0000_5600);
    check(32'(fcnt), 32'h0000_0000);
    temp = 12'hff8;
    conv(4'h9, 5'h01, 1'b1, 1'b1, 11'sh064, 1'b1);
    temp = 12'h0c8;
    conv(4'h9, 5'h01, 1'b1, 1'b0, 11'sh065, 1'b1);
    rd(4, {16'h00c8, wd(10'h064)});
    rd(4, {wd(10'h065), 16'h0000});
    spr = 1'b1;
    conv(4'hf, 5'h01, 1'b0, 1'b0, 11'sh0aa, 1'b0);
    sng = 1'b1;
    conv(4'he, 5'h01, 1'b0, 1'b0, 11'sh0aa, 1'b0);
    check(32'(fcnt), 32'h0000_0000);
    // Shared pin stays in its start role so the pin can start conversions
    sng = 1'b0;
    mode = 2'b01;
    conv(4'h8, 5'h01, 1'b0, 1'b0, 11'sh0aa, 1'b0);
    check(32'(fcnt), 32'h0000_0000);
    pin_b = 1'b0;
    cyc(4);
    pin_b = 1'b1;
    wait_idle(t);
    rd(2, 32'(wd(10'h0aa)));
    mode = 2'b11;
    cnt = 5'h03;
    cyc(2);
    check(32'(osc), 32'h0000_0000);
    u_host.frame(0, d);
    wait_idle(t);
    mode = 2'b10;
    cyc(2);
    check(32'({fcnt, osc}), 32'h0000_0003);
    rd(2, 32'(wd(10'h0aa)));
    end_of_test();
  end
endmodule : aicrf_bench
`default_nettype wire
